// >>> rtl/utr_consts.vh
// Purpose: Shared constants for the serial port core
// Assumes: Eight-bit parallel register port, three address lines
// Notes: Offsets are the three-bit register addresses
// What this block does
// R1: Alternate bus mode drives the interrupt request pin with inverted polarity.
// R2: Transmit interrupt: non-FIFO on holding empty; FIFO at or below trigger.
// R3: Receive interrupt: non-FIFO on byte held; FIFO at trigger level.
// R4: Sixteen-times clock from input clock divided by sixteen-bit two-byte divisor.
// R5: Transmit shifter is eight bits; each bit lasts sixteen ticks.
// R6: Frame is start, data bits, optional parity, then stop bits.
// R7: Data bits leave least significant first.
// R8: FIFO mode: each holding write pushes one byte into 64-entry FIFO.
// R9: Non-FIFO: holding-empty flag sets when byte moves to shifter.
// R10: Holding-empty raises transmit interrupt, status bit 1, if enable bit 1.
// R11: FIFO mode: holding-empty flag set whenever transmit FIFO is empty.
// R12: FIFO mode: transmit interrupt when fill falls to trigger level.
// R13: Transmitter-empty flag only when shifter and FIFO both empty.
// R14: Start bit sampled eight ticks after falling edge; high returns idle.
// R15: Data, parity and stop sampled sixteen ticks after previous sample.
// R16: Line status bits 2 to 4 show head character errors.
// R17: Receive FIFO holds 64 entries of eight data and three error bits.
// R18: Reading receive holding pops FIFO and updates error bits at once.
// R19: Receive holding shows oldest received character.
// R20: Receive interrupt, enable bit 0, per character or at trigger level.
// R21: Time-out when data waits four word lengths plus twelve bit times.
// R22: Word-length field 00..11 selects 5..8 data bits both ways.
`ifndef UTR_CONSTS_VH
`define UTR_CONSTS_VH
`define UTR_A_DATA 3'h0
`define UTR_A_IEN 3'h1
`define UTR_A_FIFO 3'h2
`define UTR_A_LCTL 3'h3
`define UTR_A_LSTAT 3'h5
`define UTR_LCR_DLAB 7
`define UTR_LCR_STOP 2
`define UTR_LCR_PEN 3
`define UTR_LCR_EVEN 4
`define UTR_LCR_RST 8'h00
`define UTR_IER_RST 8'h00
`define UTR_DIV_RST 8'h00
`define UTR_HALF_TICKS 4'h7
`define UTR_BIT_TICKS 4'hF
`define UTR_TO_EXTRA 6'h0C
`define UTR_ID_TIMEOUT 3'h6
`define UTR_ID_RXRDY 3'h2
`define UTR_ID_TXEMPTY 3'h1
`define UTR_RXTRG0 7'h01
`define UTR_RXTRG1 7'h10
`define UTR_RXTRG2 7'h20
`define UTR_RXTRG3 7'h38
`define UTR_TXTRG0 7'h08
`define UTR_TXTRG1 7'h10
`define UTR_TXTRG2 7'h20
`define UTR_TXTRG3 7'h38
`endif

// >>> rtl/utr_fifo.v
// Purpose: Synchronous FIFO with combinational head
// Assumes: DEPTH equals two to the power AW
// Notes: Push when full and pop when empty are ignored
`timescale 1ns/1ps
`default_nettype none
module utr_fifo #(
	parameter W = 8,
	parameter DEPTH = 64,
	parameter AW = 6
) (
	input wire clk,
	input wire rst_n,
	input wire clr,
	input wire push,
	input wire [W-1:0] din,
	input wire pop,
	output wire [W-1:0] head,
	output reg [AW:0] count_q
);
	localparam [AW:0] FULL = DEPTH[AW:0];
	reg [W-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wp_q;
	reg [AW-1:0] rp_q;
	wire do_push = push & (count_q != FULL);
	wire do_pop = pop & (count_q != {(AW+1){1'b0}});

	assign head = mem[rp_q]; // [R19]

	always @(posedge clk) begin
		if (do_push) begin
			mem[wp_q] <= din;
		end
	end

	always @(posedge clk) begin
		if (!rst_n || clr) begin
			wp_q <= {AW{1'b0}};
			rp_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
		end else begin
			if (do_push) begin
				wp_q <= wp_q + 1'b1; // [R8]
			end
			if (do_pop) begin
				rp_q <= rp_q + 1'b1; // [R18]
			end
			if (do_push && !do_pop) begin
				count_q <= count_q + 1'b1;
			end else if (do_pop && !do_push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end
endmodule // utr_fifo
`default_nettype wire

// >>> rtl/utr_core.v
// Purpose: 16x oversampled serial port core with 64-entry FIFOs
// Assumes: All inputs synchronous to MCLK; one access per strobe cycle
// Notes: DOUT is valid the cycle after a read strobe
`include "utr_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module utr_core #(
	parameter FIFO_DEPTH = 64,
	parameter FIFO_AW = 6
) (
	input wire MCLK,
	input wire RST_N,
	input wire CS_N,
	input wire RD_N,
	input wire WR_N,
	input wire [2:0] ADDR,
	input wire [7:0] DIN,
	output reg [7:0] DOUT,
	input wire MODE_ALT,
	input wire RXD,
	output wire TXD,
	output wire INT,
	output wire IRQ_N
);
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_START = 3'h1;
	localparam [2:0] ST_DATA = 3'h2;
	localparam [2:0] ST_PAR = 3'h3;
	localparam [2:0] ST_STOP = 3'h4;
	localparam [FIFO_AW:0] FULL = FIFO_DEPTH[FIFO_AW:0];
	localparam [FIFO_AW:0] NONE = {(FIFO_AW+1){1'b0}};

	////////////////////////////////////////////////////////////////
	// Register port
	reg [7:0] lcr_q;
	reg [7:0] ier_q;
	reg [7:0] dll_q;
	reg [7:0] dlm_q;
	reg fifo_en_q;
	reg [1:0] rx_trg_q;
	reg [1:0] tx_trg_q;
	reg ovr_q;
	wire wr = !CS_N && !WR_N;
	wire rd = !CS_N && !RD_N;
	wire dlab = lcr_q[`UTR_LCR_DLAB];
	wire wr_data = wr && ADDR == `UTR_A_DATA && !dlab;
	wire rd_data = rd && ADDR == `UTR_A_DATA && !dlab;
	wire wr_fcr = wr && ADDR == `UTR_A_FIFO;
	wire rd_lsr = rd && ADDR == `UTR_A_LSTAT;
	wire fifo_chg = wr_fcr && (DIN[0] != fifo_en_q);
	wire tx_clr = wr_fcr && (DIN[2] || fifo_chg);
	wire rx_clr = wr_fcr && (DIN[1] || fifo_chg);
	wire [3:0] nbits = {2'b00, lcr_q[1:0]} + 4'h5; // [R22]

	always @(posedge MCLK) begin
		if (!RST_N) begin
			lcr_q <= `UTR_LCR_RST;
			ier_q <= `UTR_IER_RST;
			dll_q <= `UTR_DIV_RST;
			dlm_q <= `UTR_DIV_RST;
			fifo_en_q <= 1'b0;
			rx_trg_q <= 2'b00;
			tx_trg_q <= 2'b00;
		end else if (wr) begin
			case (ADDR)
				`UTR_A_DATA: if (dlab) dll_q <= DIN; // [R4]
				`UTR_A_IEN: begin
					if (dlab) dlm_q <= DIN; // [R4]
					else ier_q <= {4'h0, DIN[3:0]};
				end
				`UTR_A_FIFO: begin
					fifo_en_q <= DIN[0];
					tx_trg_q <= DIN[5:4];
					rx_trg_q <= DIN[7:6];
				end
				`UTR_A_LCTL: lcr_q <= DIN;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Baud generator
	wire [15:0] divisor = {dlm_q, dll_q};
	reg [15:0] brg_q;
	reg tick_q;
	wire brg_wrap = brg_q >= divisor - 16'h0001;

	always @(posedge MCLK) begin
		if (!RST_N || divisor == 16'h0000) begin
			brg_q <= 16'h0000;
			tick_q <= 1'b0;
		end else begin
			brg_q <= brg_wrap ? 16'h0000 : brg_q + 16'h0001;
			tick_q <= brg_wrap; // [R4]
		end
	end

	////////////////////////////////////////////////////////////////
	// Transmit FIFO and shifter
	wire [7:0] tx_head;
	wire [FIFO_AW:0] tx_cnt;
	reg [2:0] tx_st_q;
	reg [7:0] tx_sh_q;
	reg [3:0] tx_tick_q;
	reg [2:0] tx_bit_q;
	reg tx_par_q;
	reg tx_stop2_q;
	reg txd_q;
	wire tx_full = fifo_en_q ? (tx_cnt == FULL) : (tx_cnt != NONE);
	wire tx_load = tick_q && tx_st_q == ST_IDLE && tx_cnt != NONE;
	wire tx_end = tick_q && tx_tick_q == `UTR_BIT_TICKS;

	utr_fifo #(
		.W(8),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_txf (
		.clk(MCLK),
		.rst_n(RST_N),
		.clr(tx_clr),
		.push(wr_data && !tx_full), // [R8]
		.din(DIN),
		.pop(tx_load),
		.head(tx_head),
		.count_q(tx_cnt)
	);

	assign TXD = txd_q;

	always @(posedge MCLK) begin
		if (!RST_N) begin
			tx_st_q <= ST_IDLE;
			tx_sh_q <= 8'h00;
			tx_tick_q <= 4'h0;
			tx_bit_q <= 3'h0;
			tx_par_q <= 1'b0;
			tx_stop2_q <= 1'b0;
			txd_q <= 1'b1;
		end else begin
			if (tick_q && tx_st_q != ST_IDLE) begin
				tx_tick_q <= tx_tick_q + 4'h1; // [R5]
			end
			case (tx_st_q)
				ST_IDLE: begin
					if (tx_load) begin
						tx_sh_q <= tx_head; // [R9]
						txd_q <= 1'b0; // [R6]
						tx_tick_q <= 4'h0;
						tx_st_q <= ST_START;
					end
				end
				ST_START: begin
					if (tx_end) begin
						txd_q <= tx_sh_q[0]; // [R7]
						tx_par_q <= tx_sh_q[0];
						tx_sh_q <= {1'b0, tx_sh_q[7:1]};
						tx_bit_q <= 3'h0;
						tx_st_q <= ST_DATA;
					end
				end
				ST_DATA: begin
					if (tx_end) begin
						if ({1'b0, tx_bit_q} == nbits - 4'h1) begin
							if (lcr_q[`UTR_LCR_PEN]) begin
								txd_q <= tx_par_q ^ ~lcr_q[`UTR_LCR_EVEN];
								tx_st_q <= ST_PAR;
							end else begin
								txd_q <= 1'b1;
								tx_stop2_q <= lcr_q[`UTR_LCR_STOP];
								tx_st_q <= ST_STOP;
							end
						end else begin
							txd_q <= tx_sh_q[0]; // [R7]
							tx_par_q <= tx_par_q ^ tx_sh_q[0];
							tx_sh_q <= {1'b0, tx_sh_q[7:1]};
							tx_bit_q <= tx_bit_q + 3'h1;
						end
					end
				end
				ST_PAR: begin
					if (tx_end) begin
						txd_q <= 1'b1; // [R6]
						tx_stop2_q <= lcr_q[`UTR_LCR_STOP];
						tx_st_q <= ST_STOP;
					end
				end
				ST_STOP: begin
					if (tx_end && tx_stop2_q) tx_stop2_q <= 1'b0;
					else if (tx_end) tx_st_q <= ST_IDLE;
				end
				default: begin
					tx_st_q <= ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Receive shifter and FIFO
	wire [10:0] rx_head;
	wire [FIFO_AW:0] rx_cnt;
	reg [2:0] rx_st_q;
	reg [7:0] rx_sh_q;
	reg [3:0] rx_tick_q;
	reg [2:0] rx_bit_q;
	reg rx_par_q;
	reg rx_pe_q;
	reg rx_prev_q;
	reg rx_push_q;
	reg [10:0] rx_word_q;
	wire rx_full = fifo_en_q ? (rx_cnt == FULL) : (rx_cnt != NONE);
	wire rx_half = tick_q && rx_tick_q == `UTR_HALF_TICKS;
	wire rx_mid = tick_q && rx_tick_q == `UTR_BIT_TICKS;
	wire rx_has = rx_cnt != NONE;
	wire [7:0] rx_data = rx_sh_q >> (4'h8 - nbits);

	utr_fifo #(
		.W(11),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_rxf (
		.clk(MCLK),
		.rst_n(RST_N),
		.clr(rx_clr),
		.push(rx_push_q && !rx_full), // [R17]
		.din(rx_word_q),
		.pop(rd_data), // [R18]
		.head(rx_head),
		.count_q(rx_cnt)
	);

	always @(posedge MCLK) begin
		if (!RST_N) begin
			rx_st_q <= ST_IDLE;
			rx_sh_q <= 8'h00;
			rx_tick_q <= 4'h0;
			rx_bit_q <= 3'h0;
			rx_par_q <= 1'b0;
			rx_pe_q <= 1'b0;
			rx_prev_q <= 1'b1;
			rx_push_q <= 1'b0;
			rx_word_q <= 11'h000;
		end else begin
			rx_prev_q <= RXD;
			rx_push_q <= 1'b0;
			if (tick_q && rx_st_q != ST_IDLE) begin
				rx_tick_q <= rx_tick_q + 4'h1;
			end
			case (rx_st_q)
				ST_IDLE: begin
					if (rx_prev_q && !RXD) begin
						rx_tick_q <= 4'h0;
						rx_st_q <= ST_START;
					end
				end
				ST_START: begin
					if (rx_half) begin
						rx_tick_q <= 4'h0;
						rx_bit_q <= 3'h0;
						rx_par_q <= 1'b0;
						rx_pe_q <= 1'b0;
						rx_st_q <= RXD ? ST_IDLE : ST_DATA; // [R14]
					end
				end
				ST_DATA: begin
					if (rx_mid) begin
						rx_sh_q <= {RXD, rx_sh_q[7:1]}; // [R15]
						rx_par_q <= rx_par_q ^ RXD;
						rx_bit_q <= rx_bit_q + 3'h1;
						if ({1'b0, rx_bit_q} == nbits - 4'h1) begin
							rx_st_q <= lcr_q[`UTR_LCR_PEN] ? ST_PAR : ST_STOP;
						end
					end
				end
				ST_PAR: begin
					if (rx_mid) begin
						rx_pe_q <= rx_par_q ^ RXD ^ ~lcr_q[`UTR_LCR_EVEN]; // [R15]
						rx_st_q <= ST_STOP;
					end
				end
				ST_STOP: begin
					if (rx_mid) begin
						rx_push_q <= 1'b1;
						rx_word_q <= {!RXD && rx_data == 8'h00, !RXD, rx_pe_q, rx_data};
						rx_st_q <= ST_IDLE;
					end
				end
				default: begin
					rx_st_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Overrun: set wins over the clear from a status read
	always @(posedge MCLK) begin
		if (!RST_N) ovr_q <= 1'b0;
		else if (rx_push_q && rx_full) ovr_q <= 1'b1;
		else if (rd_lsr || rx_clr) ovr_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// Receive time-out
	reg [9:0] to_cnt_q;
	wire [5:0] to_bits = {nbits, 2'b00} + `UTR_TO_EXTRA;
	wire [9:0] to_lim = {to_bits, 4'h0};
	wire to_hit = fifo_en_q && rx_has && to_cnt_q == to_lim; // [R21]

	always @(posedge MCLK) begin
		if (!RST_N || rx_push_q || rd_data || !rx_has || !fifo_en_q) to_cnt_q <= 10'h000;
		else if (tick_q && to_cnt_q != to_lim) to_cnt_q <= to_cnt_q + 10'h001; // [R21]
	end

	////////////////////////////////////////////////////////////////
	// Status, interrupt and read-back
	wire [6:0] rx_lvl = rx_trg_q[1] ? (rx_trg_q[0] ? `UTR_RXTRG3 : `UTR_RXTRG2)
		: (rx_trg_q[0] ? `UTR_RXTRG1 : `UTR_RXTRG0);
	wire [6:0] tx_lvl = tx_trg_q[1] ? (tx_trg_q[0] ? `UTR_TXTRG3 : `UTR_TXTRG2)
		: (tx_trg_q[0] ? `UTR_TXTRG1 : `UTR_TXTRG0);
	wire [15:0] rx_cnt16 = {{(15-FIFO_AW){1'b0}}, rx_cnt};
	wire [15:0] tx_cnt16 = {{(15-FIFO_AW){1'b0}}, tx_cnt};
	wire thr_empty = tx_cnt == NONE; // [R9] [R11]
	wire tsr_empty = thr_empty && tx_st_q == ST_IDLE; // [R13]
	wire [2:0] rx_err = rx_has ? rx_head[10:8] : 3'h0; // [R16]
	wire [7:0] line_status = {1'b0, tsr_empty, thr_empty, rx_err, ovr_q, rx_has};
	wire tx_cond = fifo_en_q ? (tx_cnt16 <= {9'h000, tx_lvl}) : thr_empty; // [R2] [R12]
	wire rx_cond = fifo_en_q ? (rx_cnt16 >= {9'h000, rx_lvl}) : rx_has; // [R3] [R20]
	wire rx_irq = ier_q[0] && rx_cond; // [R20]
	wire to_irq = ier_q[0] && to_hit; // [R21]
	wire tx_irq = ier_q[1] && tx_cond; // [R10]
	wire [2:0] isr_id = to_irq ? `UTR_ID_TIMEOUT : rx_irq ? `UTR_ID_RXRDY
		: tx_irq ? `UTR_ID_TXEMPTY : 3'h0; // [R10]
	wire pend = to_irq || rx_irq || tx_irq;
	wire [7:0] interrupt_status = {fifo_en_q, fifo_en_q, 2'b00, isr_id, !pend};

	reg int_q;
	reg irq_n_q;
	always @(posedge MCLK) begin
		if (!RST_N) begin
			int_q <= 1'b0;
			irq_n_q <= 1'b1;
			DOUT <= 8'h00;
		end else begin
			int_q <= pend && !MODE_ALT;
			irq_n_q <= !(pend && MODE_ALT); // [R1]
			if (rd) begin
				case (ADDR)
					`UTR_A_DATA: DOUT <= dlab ? dll_q : rx_head[7:0]; // [R19]
					`UTR_A_IEN: DOUT <= dlab ? dlm_q : ier_q;
					`UTR_A_FIFO: DOUT <= interrupt_status;
					`UTR_A_LCTL: DOUT <= lcr_q;
					`UTR_A_LSTAT: DOUT <= line_status; // [R16]
					default: DOUT <= 8'h00;
				endcase
			end
		end
	end

	assign INT = int_q;
	assign IRQ_N = irq_n_q;
endmodule // utr_core
`default_nettype wire

// >>> verification/utr_core_chk.sv
// Purpose: Port-level assertions for the serial port core
// Assumes: Divisor programmed to 1, so one serial bit is 16 MCLK cycles
// Notes: Bound to utr_core from the bench top file
`timescale 1ns/1ps
`default_nettype none
module utr_core_chk (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic CS_N,
	input wire logic RD_N,
	input wire logic WR_N,
	input wire logic [2:0] ADDR,
	input wire logic [7:0] DIN,
	input wire logic [7:0] DOUT,
	input wire logic MODE_ALT,
	input wire logic RXD,
	input wire logic TXD,
	input wire logic INT,
	input wire logic IRQ_N
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	logic rd_lsr;
	assign rd_lsr = !CS_N && !RD_N && ADDR == 3'h5;
	sequence low_bit;
		(!TXD) [*8] ##1 (!TXD) [*8];
	endsequence
	sequence high_bit;
		TXD [*8] ##1 TXD [*8];
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	int_excl_a: assert property (!(INT && !IRQ_N))
		else $error("both interrupt pins active");
	int_alt_a: assert property (MODE_ALT && $past(MODE_ALT) |-> !INT)
		else $error("INT driven in alternate mode");
	irq_norm_a: assert property (!MODE_ALT && !$past(MODE_ALT) |-> IRQ_N)
		else $error("IRQ_N driven in normal mode");
	bit_low_a: assert property ($fell(TXD) |-> low_bit)
		else $error("low serial bit shorter than 16 ticks");
	bit_high_a: assert property ($rose(TXD) |-> high_bit)
		else $error("high serial bit shorter than 16 ticks");
	dout_hold_a: assert property (!$stable(DOUT) |-> $past(!CS_N && !RD_N))
		else $error("read data changed without a read");
	temt_idle_a: assert property (rd_lsr |=> !DOUT[6] || (DOUT[5] && TXD))
		else $error("transmitter empty while busy");
	temt_busy_a: assert property (rd_lsr && !TXD |=> !DOUT[6])
		else $error("transmitter empty during a frame");
endmodule // utr_core_chk
`default_nettype wire

// >>> verification/utr_remote.sv
// Purpose: Remote serial port facing the core's serial pins
// Assumes: Divisor 1, so one bit is 16 MCLK cycles; parity seen as ninth data bit
// Notes: Received characters collect in rx_q, right aligned
`timescale 1ns/1ps
`default_nettype none
module utr_remote (
	input wire logic clk,
	input wire logic txd,
	output logic rxd
);
	int nbits = 8;
	logic [7:0] rx_q[$];
	logic par_seen = 1'b0;
	initial rxd = 1'b1;
	task automatic hold(input logic lvl, input int n);
		rxd = lvl;
		repeat (n) @(negedge clk);
	endtask
	// Stop level selectable to provoke a framing error
	task automatic send(input logic [8:0] b, input logic stop);
		@(negedge clk);
		hold(1'b0, 16);
		for (int i = 0; i < nbits; i++) hold(b[i], 16);
		hold(stop, 16);
		hold(1'b1, 16);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always begin : rx_side
		logic [8:0] b;
		@(negedge txd);
		b = 9'h000;
		repeat (8) @(posedge clk);
		if (txd === 1'b0) begin
			for (int i = 0; i < nbits; i++) begin
				repeat (16) @(posedge clk);
				b[i] = txd;
			end
			repeat (16) @(posedge clk);
			rx_q.push_back(b[7:0]);
			par_seen = b[8];
		end
	end
endmodule // utr_remote
`default_nettype wire

// >>> verification/test_uart_tx_rx_core.sv
// Purpose: Self-checking bench for the serial port core
// Assumes: Divisor 1 throughout; inputs change on falling MCLK
// Notes: Remote serial port model drives RXD and decodes TXD
`timescale 1ns/1ps
`default_nettype none
module test_uart_tx_rx_core;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic cs_n = 1'b1;
	logic rd_n = 1'b1;
	logic wr_n = 1'b1;
	logic [2:0] addr = 3'h0;
	logic [7:0] din = 8'h00;
	logic mode_alt = 1'b0;
	logic rxd;
	logic txd;
	logic int_hi;
	logic irq_n;
	logic [7:0] dout;
	logic [7:0] v;
	int mismatches = 0;
	int checks_done = 0;
	always #2 mclk = ~mclk;
	utr_core dut (.MCLK(mclk), .RST_N(rst_n), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n),
		.ADDR(addr), .DIN(din), .DOUT(dout), .MODE_ALT(mode_alt), .RXD(rxd), .TXD(txd),
		.INT(int_hi), .IRQ_N(irq_n));
	utr_remote rem (.clk(mclk), .txd(txd), .rxd(rxd));
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge mclk);
		cs_n = 1'b0;
		wr_n = 1'b0;
		addr = a;
		din = d;
		@(negedge mclk);
		cs_n = 1'b1;
		wr_n = 1'b1;
	endtask
	task automatic rd(input logic [2:0] a);
		@(negedge mclk);
		cs_n = 1'b0;
		rd_n = 1'b0;
		addr = a;
		@(negedge mclk);
		cs_n = 1'b1;
		rd_n = 1'b1;
		v = dout;
	endtask
	task automatic wait_rx(input int n);
		for (int i = 0; i < 4000 && rem.rx_q.size() < n; i++) @(negedge mclk);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd(3'h5);
		check(v, 8'h60);
		rd(3'h2);
		check(v, 8'h01);
		wr(3'h3, 8'h80);
		wr(3'h0, 8'h01);
		wr(3'h1, 8'h00);
		rd(3'h0);
		check(v, 8'h01);
		wr(3'h3, 8'h03);
	endtask
	task automatic t_tx_single();
		wr(3'h1, 8'h02);
		repeat (2) @(negedge mclk);
		check({7'h00, int_hi}, 8'h01);
		wr(3'h0, 8'h3C);
		wr(3'h0, 8'hC3);
		repeat (20) @(negedge mclk);
		rd(3'h5);
		check(v & 8'h60, 8'h00);
		check({7'h00, int_hi}, 8'h00);
		wait_rx(2);
		check(rem.rx_q[0], 8'h3C);
		check(rem.rx_q[1], 8'hC3);
		repeat (20) @(negedge mclk);
		rd(3'h5);
		check(v, 8'h60);
		check({7'h00, int_hi}, 8'h01);
		wr(3'h1, 8'h00);
	endtask
	task automatic t_word_len();
		wr(3'h1, 8'h01);
		for (int k = 0; k < 4; k++) begin
			wr(3'h3, 8'(k));
			rem.nbits = 5 + k;
			rem.rx_q.delete();
			wr(3'h0, 8'hB6);
			wait_rx(1);
			check(rem.rx_q[0], 8'hB6 & (8'hFF >> (3 - k)));
			rem.send(8'h6D, 1'b1);
			check({7'h00, int_hi}, 8'h01);
			rd(3'h0);
			check(v, 8'h6D & (8'hFF >> (3 - k)));
			@(negedge mclk);
			check({7'h00, int_hi}, 8'h00);
		end
		wr(3'h3, 8'h03);
		rem.nbits = 8;
	endtask
	task automatic t_rx_errors();
		wr(3'h2, 8'h01);
		rem.send(8'h44, 1'b1);
		rem.send(8'h55, 1'b0);
		rem.send(8'h66, 1'b1);
		rd(3'h5);
		check(v & 8'h1C, 8'h00);
		rd(3'h0);
		check(v, 8'h44);
		rd(3'h5);
		check(v & 8'h1C, 8'h08);
		rd(3'h0);
		check(v, 8'h55);
		rd(3'h5);
		check(v & 8'h1C, 8'h00);
		rd(3'h0);
		check(v, 8'h66);
	endtask
	task automatic t_timeout();
		wr(3'h2, 8'h41);
		rem.send(8'h77, 1'b1);
		repeat (660) @(negedge mclk);
		check({7'h00, int_hi}, 8'h00);
		for (int i = 0; i < 80 && int_hi !== 1'b1; i++) @(negedge mclk);
		check({7'h00, int_hi}, 8'h01);
		mode_alt = 1'b1;
		repeat (2) @(negedge mclk);
		check({6'h00, int_hi, irq_n}, 8'h00);
		mode_alt = 1'b0;
		rd(3'h2);
		check(v, 8'hCC);
		rd(3'h0);
		check(v, 8'h77);
	endtask
	task automatic t_tx_fifo();
		wr(3'h2, 8'h01);
		wr(3'h1, 8'h02);
		rem.rx_q.delete();
		for (int i = 0; i < 12; i++) wr(3'h0, 8'h10 + 8'(i));
		rd(3'h5);
		check(v & 8'h60, 8'h00);
		wait_rx(3);
		check({7'h00, int_hi}, 8'h00);
		wait_rx(4);
		check({7'h00, int_hi}, 8'h01);
		wait_rx(12);
		for (int i = 0; i < 12; i++) check(rem.rx_q[i], 8'h10 + 8'(i));
		repeat (20) @(negedge mclk);
		rd(3'h5);
		check(v, 8'h60);
	endtask
	task automatic t_parity();
		wr(3'h3, 8'h1B);
		rem.nbits = 9;
		rem.rx_q.delete();
		wr(3'h0, 8'h01);
		wait_rx(1);
		check(rem.rx_q[0], 8'h01);
		check({7'h00, rem.par_seen}, 8'h01);
		rem.send(9'h001, 1'b1);
		rem.send(9'h101, 1'b1);
		rd(3'h5);
		check(v & 8'h1C, 8'h04);
		rd(3'h0);
		check(v, 8'h01);
		rd(3'h5);
		check(v & 8'h1C, 8'h00);
		rd(3'h0);
		check(v, 8'h01);
		wr(3'h3, 8'h03);
		rem.nbits = 8;
	endtask
	task automatic t_glitch();
		rem.hold(1'b0, 5);
		rem.hold(1'b1, 200);
		rd(3'h5);
		check(v & 8'h01, 8'h00);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		#100000;
		mismatches++;
		tally_and_finish();
	end
	initial begin
		repeat (4) @(negedge mclk);
		rst_n = 1'b1;
		t_reset();
		t_tx_single();
		t_word_len();
		t_rx_errors();
		t_timeout();
		t_tx_fifo();
		t_parity();
		t_glitch();
		tally_and_finish();
	end
endmodule // test_uart_tx_rx_core
bind utr_core utr_core_chk chk (.MCLK(MCLK), .RST_N(RST_N), .CS_N(CS_N), .RD_N(RD_N),
	.WR_N(WR_N), .ADDR(ADDR), .DIN(DIN), .DOUT(DOUT), .MODE_ALT(MODE_ALT), .RXD(RXD),
	.TXD(TXD), .INT(INT), .IRQ_N(IRQ_N));
`default_nettype wire
